// file: rtl/rdl_pkg.sv
// shared constants and types for the register default loader
`default_nettype none
package rdl_pkg;
    localparam int NVM_AW = 10;
    localparam int REG_AW = 8;
    localparam int CNT_W  = 8;

    // ------------------------------------------------------------
    // memory layout
    // ------------------------------------------------------------
    localparam logic [NVM_AW-1:0] PAGE0_LAST    = 10'h03f;
    localparam logic [NVM_AW-1:0] DEFAULTS_BASE = 10'h040;
    localparam logic [CNT_W-1:0]  DEFAULT_COUNT = 8'h60;
    localparam logic [REG_AW-1:0] DEFAULT_REG0  = 8'h00;

    // ------------------------------------------------------------
    // protocol settings areas and their target registers
    // ------------------------------------------------------------
    localparam logic [REG_AW-1:0] TX_REG_FIRST = 8'h28;
    localparam logic [CNT_W-1:0]  TX_LEN       = 8'h10;
    localparam logic [REG_AW-1:0] RX_REG_FIRST = 8'h38;
    localparam logic [CNT_W-1:0]  RX_LEN       = 8'h08;

    typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE} rdl_state_t;
    typedef enum logic [1:0] {PH_DEFAULTS, PH_TX, PH_RX} rdl_phase_t;
endpackage
`default_nettype wire

// file: rtl/rdl_src_addr.sv
// source address of one protocol settings set in nonvolatile memory
`timescale 1ns/1ps
`default_nettype none
module rdl_src_addr #(
    parameter int AW = 10
) (
    input  wire logic [AW-1:0] areaBase,
    input  wire logic [7:0]    protoSel,
    input  wire logic [7:0]    setLen,
    output logic      [AW-1:0] srcAddr
);
    logic [15:0] offset;

    // wraps inside the memory; a base near the top folds back
    assign offset  = protoSel * setLen;
    assign srcAddr = areaBase + offset[AW-1:0];
endmodule
`default_nettype wire

// file: rtl/rdl_loader.sv
// copies register defaults and protocol settings from nonvolatile memory
`timescale 1ns/1ps
`default_nettype none
// Contract
// - defaults come from nonvolatile bytes copied into registers, not fixed constants
// - only read/write or dynamic bits of a register take the stored byte
// - protocol source locations follow selected protocol and user-set area bases
// - the default copy reruns after every startup, so edited bytes take effect
// - protocol load command copies a stored protocol settings set into registers
// - defaults start at byte 40h, one byte per register in register order
// - first page holds production data and never serves as defaults
module rdl_loader
    import rdl_pkg::*;
#(
    parameter int DEF_COUNT = 96
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic                      startupDone,
    input  wire logic                      protocol_settings_load,
    input  wire logic [7:0]                txProtocol,
    input  wire logic [7:0]                rxProtocol,
    input  wire logic [rdl_pkg::NVM_AW-1:0] txAreaBase,
    input  wire logic [rdl_pkg::NVM_AW-1:0] rxAreaBase,
    output logic                           nvmRdReq,
    output logic      [rdl_pkg::NVM_AW-1:0] nvmAddr,
    input  wire logic [7:0]                nvmRdData,
    input  wire logic                      nvmRdValid,
    output logic                           regWe,
    output logic      [rdl_pkg::REG_AW-1:0] regWrAddr,
    output logic      [7:0]                regWrData,
    output logic      [7:0]                regWrMask,
    input  wire logic [7:0]                writableMask,
    output logic                           hostReady,
    output logic                           loaderBusy,
    output logic                           protoDone
);
    import rdl_pkg::*;

    typedef struct packed {
        rdl_state_t          st;
        rdl_phase_t          ph;
        logic [NVM_AW-1:0]   src;
        logic [REG_AW-1:0]   dst;
        logic [CNT_W-1:0]    remain;
        logic [NVM_AW-1:0]   rxStart;
        logic                pend;
        logic [7:0]          txSel;
        logic [7:0]          rxSel;
        logic                we;
        logic [7:0]          data;
        logic [7:0]          mask;
        logic                ready;
        logic                done;
    } rdl_regs_t;

    rdl_regs_t           r;
    rdl_regs_t           next_r;
    logic [NVM_AW-1:0]   txSrc;
    logic [NVM_AW-1:0]   rxSrc;

    // ------------------------------------------------------------
    // protocol source addresses
    // ------------------------------------------------------------
    rdl_src_addr #(.AW(NVM_AW)) uTxSrc (
        .areaBase (txAreaBase),
        .protoSel (r.txSel),
        .setLen   (TX_LEN),
        .srcAddr  (txSrc)
    );

    rdl_src_addr #(.AW(NVM_AW)) uRxSrc (
        .areaBase (rxAreaBase),
        .protoSel (r.rxSel),
        .setLen   (RX_LEN),
        .srcAddr  (rxSrc)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_r      = r;
        next_r.we   = 1'b0;
        next_r.done = 1'b0;
        // a command in the same cycle as the clear is kept
        if (protocol_settings_load) begin
            next_r.pend  = 1'b1;
            next_r.txSel = txProtocol;
            next_r.rxSel = rxProtocol;
        end
        unique case (r.st)
            S_IDLE: begin
                if (r.pend && !protocol_settings_load) begin
                    next_r.pend   = 1'b0;
                    next_r.ph     = PH_TX;
                    next_r.src    = txSrc;
                    next_r.dst    = TX_REG_FIRST;
                    next_r.remain = TX_LEN;
                    // rx source fixed now; a queued command may change the index
                    next_r.rxStart = rxSrc;
                    next_r.st     = S_READ;
                end
            end
            S_READ: begin
                if (nvmRdValid) begin
                    next_r.we   = 1'b1;
                    next_r.data = nvmRdData;
                    next_r.mask = writableMask;
                    next_r.st   = S_WRITE;
                end
            end
            S_WRITE: begin
                next_r.src    = r.src + 10'h001;
                next_r.dst    = r.dst + 8'h01;
                next_r.remain = r.remain - 8'h01;
                next_r.st     = S_READ;
                if (r.remain == 8'h01) begin
                    unique case (r.ph)
                        PH_DEFAULTS: begin
                            next_r.ready = 1'b1;
                            next_r.st    = S_IDLE;
                        end
                        PH_TX: begin
                            next_r.ph     = PH_RX;
                            next_r.src    = r.rxStart;
                            next_r.dst    = RX_REG_FIRST;
                            next_r.remain = RX_LEN;
                        end
                        PH_RX: begin
                            next_r.done = 1'b1;
                            next_r.st   = S_IDLE;
                        end
                        default: next_r.st = S_IDLE;
                    endcase
                end
            end
            default: next_r.st = S_IDLE;
        endcase
        // startup restarts the whole default copy and blocks the host
        if (startupDone) begin
            next_r.st     = S_READ;
            next_r.ph     = PH_DEFAULTS;
            next_r.src    = DEFAULTS_BASE;
            next_r.dst    = DEFAULT_REG0;
            next_r.remain = DEF_COUNT[CNT_W-1:0];
            next_r.ready  = 1'b0;
            next_r.we     = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            // reset starts a default copy; page 0 is skipped by the base
            r        <= '0;
            r.st     <= S_READ;
            r.ph     <= PH_DEFAULTS;
            r.src    <= DEFAULTS_BASE;
            r.dst    <= DEFAULT_REG0;
            r.remain <= DEF_COUNT[CNT_W-1:0];
        end else begin
            r <= next_r;
        end
    end

    assign nvmRdReq   = (r.st == S_READ);
    assign nvmAddr    = r.src;
    assign regWe      = r.we;
    assign regWrAddr  = r.dst;
    assign regWrData  = r.data;
    assign regWrMask  = r.mask;
    assign hostReady  = r.ready;
    assign loaderBusy = (r.st != S_IDLE);
    assign protoDone  = r.done;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_write_from_nvm;
        @(posedge core_clk) disable iff (rst)
        regWe |-> $past(nvmRdValid) && $past(nvmRdReq) && regWrData == $past(nvmRdData);
    endproperty
    a_write_from_nvm: assert property (p_write_from_nvm) else $error("write without read");

    property p_mask_writable;
        @(posedge core_clk) disable iff (rst)
        regWe |-> regWrMask == $past(writableMask);
    endproperty
    a_mask_writable: assert property (p_mask_writable) else $error("mask not writable set");

    property p_tx_source;
        @(posedge core_clk) disable iff (rst)
        (r.st == S_IDLE && r.pend && !protocol_settings_load && !startupDone)
            |=> nvmRdReq && nvmAddr == $past(txSrc) && regWrAddr == TX_REG_FIRST;
    endproperty
    a_tx_source: assert property (p_tx_source) else $error("protocol source wrong");

    property p_startup_restart;
        @(posedge core_clk) disable iff (rst)
        startupDone |=> nvmRdReq && nvmAddr == DEFAULTS_BASE && !hostReady;
    endproperty
    a_startup_restart: assert property (p_startup_restart) else $error("no restart");

    property p_proto_done;
        @(posedge core_clk) disable iff (rst)
        (r.st == S_WRITE && r.ph == PH_RX && r.remain == 8'h01 && !startupDone)
            |=> protoDone ##1 !protoDone;
    endproperty
    a_proto_done: assert property (p_proto_done) else $error("protocol load not ended");

    property p_byte_order;
        @(posedge core_clk) disable iff (rst)
        (r.st == S_WRITE && r.remain != 8'h01 && !startupDone)
            |=> nvmAddr == $past(nvmAddr) + 10'h001 && regWrAddr == $past(regWrAddr) + 8'h01;
    endproperty
    a_byte_order: assert property (p_byte_order) else $error("byte order broken");

    property p_no_page0;
        @(posedge core_clk) disable iff (rst)
        (nvmRdReq && r.ph == PH_DEFAULTS) |-> nvmAddr > PAGE0_LAST;
    endproperty
    a_no_page0: assert property (p_no_page0) else $error("defaults read page 0");

    property p_ready_after_copy;
        @(posedge core_clk) disable iff (rst)
        (r.ph == PH_DEFAULTS && r.st != S_IDLE) |-> !hostReady;
    endproperty
    a_ready_after_copy: assert property (p_ready_after_copy) else $error("host early");

    property p_req_held;
        @(posedge core_clk) disable iff (rst)
        (nvmRdReq && !nvmRdValid && !startupDone) |=> nvmRdReq && $stable(nvmAddr);
    endproperty
    a_req_held: assert property (p_req_held) else $error("read request dropped");
endmodule
`default_nettype wire

// file: bench/rdl_nvm_model.sv
// memory and register file model facing the loader
`timescale 1ns/1ps
`default_nettype none
module rdl_nvm_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       slow,
    input  wire logic       nvmRdReq,
    input  wire logic [9:0] nvmAddr,
    output logic      [7:0] nvmRdData,
    output logic            nvmRdValid,
    input  wire logic       regWe,
    input  wire logic [7:0] regWrAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic [7:0] regWrMask,
    output logic      [7:0] writableMask
);
    logic [7:0] mem [1024];
    logic [7:0] regs [256];
    logic [3:0] waitCnt;
    int         lowReads;
    // masks follow the low four register address bits so a missed mask shows up
    assign writableMask = 8'hf0 | {4'h0, regWrAddr[3:0]};
    initial begin
        for (int a = 0; a < 1024; a++) begin
            mem[a] = a[7:0] ^ 8'h3c ^ {6'h0, a[9:8]};
        end
        for (int r = 0; r < 256; r++) begin
            regs[r] = 8'h00;
        end
    end
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            nvmRdValid <= 1'b0;
            waitCnt <= 4'h0;
            nvmRdData <= 8'h00;
            lowReads <= 0;
        end else begin
            nvmRdValid <= 1'b0;
            // idle data line toggles so stale bytes are never mistaken for answers
            nvmRdData <= ~nvmRdData;
            if (nvmRdReq && !nvmRdValid) begin
                waitCnt <= waitCnt + 4'h1;
                if (waitCnt >= (slow ? 4'h3 : 4'h0)) begin
                    nvmRdValid <= 1'b1;
                    nvmRdData <= mem[nvmAddr];
                    waitCnt <= 4'h0;
                    if (nvmAddr < 10'h040) begin
                        lowReads <= lowReads + 1;
                    end
                end
            end
            if (regWe) begin
                regs[regWrAddr] <= (regs[regWrAddr] & ~regWrMask) | (regWrData & regWrMask);
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/tb_rdl_loader.sv
// self-checking testbench for the register default loader
`timescale 1ns/1ps
`default_nettype none
module tb_rdl_loader;
    import rdl_pkg::*;
    logic              core_clk, rst, startupDone, protocol_settings_load, slow;
    logic [7:0]        txProtocol, rxProtocol, nvmRdData, regWrData, regWrMask, writableMask;
    logic [NVM_AW-1:0] txAreaBase, rxAreaBase, nvmAddr;
    logic              nvmRdReq, nvmRdValid, regWe, hostReady, loaderBusy, protoDone;
    logic [REG_AW-1:0] regWrAddr;
    logic [7:0]        expReg [256];
    int                nErrors, checkCount;
    rdl_loader #(.DEF_COUNT(4)) i_rdl_loader (.core_clk(core_clk), .rst(rst),
        .startupDone(startupDone), .protocol_settings_load(protocol_settings_load),
        .txProtocol(txProtocol), .rxProtocol(rxProtocol), .txAreaBase(txAreaBase),
        .rxAreaBase(rxAreaBase), .nvmRdReq(nvmRdReq), .nvmAddr(nvmAddr),
        .nvmRdData(nvmRdData), .nvmRdValid(nvmRdValid), .regWe(regWe),
        .regWrAddr(regWrAddr), .regWrData(regWrData), .regWrMask(regWrMask),
        .writableMask(writableMask), .hostReady(hostReady), .loaderBusy(loaderBusy),
        .protoDone(protoDone));
    rdl_nvm_model i_rdl_nvm_model (.core_clk(core_clk), .rst(rst), .slow(slow),
        .nvmRdReq(nvmRdReq), .nvmAddr(nvmAddr), .nvmRdData(nvmRdData),
        .nvmRdValid(nvmRdValid), .regWe(regWe), .regWrAddr(regWrAddr),
        .regWrData(regWrData), .regWrMask(regWrMask), .writableMask(writableMask));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checkCount++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrapUp();
        $display("checks %0d errors %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic waitFor(input bit proto);
        for (int i = 0; i < 3000; i++) begin
            @(posedge core_clk);
            #1;
            if (proto ? protoDone === 1'b1 : hostReady === 1'b1) return;
        end
        nErrors++;
        wrapUp();
    endtask
    // expected registers after a masked copy of n stored bytes
    task automatic apply(input int r, input int src, input int n);
        logic [7:0] m;
        for (int i = 0; i < n; i++) begin
            m = 8'hf0 | 8'((r + i) % 16);
            expReg[r+i] = (expReg[r+i] & ~m) | (i_rdl_nvm_model.mem[src+i] & m);
        end
    endtask
    task automatic checkRegs(input int first, input int n);
        for (int r = first; r < first + n; r++) cmp8(i_rdl_nvm_model.regs[r], expReg[r]);
    endtask
    task automatic pulseCmd(input logic [7:0] tx, input logic [7:0] rx);
        @(posedge core_clk);
        #1 protocol_settings_load = 1'b1;
        txProtocol = tx;
        rxProtocol = rx;
        @(posedge core_clk);
        #1 protocol_settings_load = 1'b0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic startupCopy();
        waitFor(0);
        apply(0, 'h040, 4);
        checkRegs(0, 64);
        cmp8(8'(i_rdl_nvm_model.lowReads), 8'h00);
        cmp8({7'h0, loaderBusy}, 8'h00);
    endtask
    task automatic protoLoad();
        pulseCmd(8'h01, 8'h02);
        waitFor(1);
        apply('h28, 'h110, 16);
        apply('h38, 'h210, 8);
        checkRegs(0, 72);
    endtask
    // a command during a running load queues a second load
    task automatic queueLoad();
        pulseCmd(8'h02, 8'h01);
        repeat (4) @(posedge core_clk);
        pulseCmd(8'h03, 8'h00);
        waitFor(1);
        apply('h28, 'h120, 16);
        apply('h38, 'h208, 8);
        checkRegs('h28, 24);
        waitFor(1);
        apply('h28, 'h130, 16);
        apply('h38, 'h200, 8);
        checkRegs('h28, 24);
    endtask
    task automatic restartEdited();
        slow = 1'b1;
        i_rdl_nvm_model.mem['h041] = 8'ha5;
        @(posedge core_clk);
        #1 startupDone = 1'b1;
        @(posedge core_clk);
        #1 startupDone = 1'b0;
        pulseCmd(8'h00, 8'h03);
        cmp8({7'h0, hostReady}, 8'h00);
        waitFor(0);
        apply(0, 'h040, 4);
        checkRegs(0, 4);
        waitFor(1);
        apply('h28, 'h100, 16);
        apply('h38, 'h218, 8);
        checkRegs(0, 72);
    endtask
    initial begin
        rst = 1'b1;
        startupDone = 1'b0;
        protocol_settings_load = 1'b0;
        slow = 1'b0;
        txProtocol = 8'h00;
        rxProtocol = 8'h00;
        txAreaBase = 10'h100;
        rxAreaBase = 10'h200;
        nErrors = 0;
        checkCount = 0;
        for (int r = 0; r < 256; r++) expReg[r] = 8'h00;
        repeat (16) @(posedge core_clk);
        #1 rst = 1'b0;
        startupCopy();
        protoLoad();
        queueLoad();
        restartEdited();
        wrapUp();
    end
endmodule
`default_nettype wire
